// ==== hw/sfl_dev.sv ====
// Flash device end: framing, write-arm latch, lock bytes and erase cycles.
//
// Decided for this implementation: the address map and register access over APB.
`timescale 1ns/1ps
module sfl_dev #(
  parameter int PAGE_CLEAR_TIME_US = 100,
  parameter int BLOCK4K_WIPE_TIME_US = 200,
  parameter int BLOCK64K_WIPE_TIME_US = 400,
  parameter logic [7:0] OPC_ARM = sfl_pkg::OPC_ARM_DEF,
  parameter logic [7:0] OPC_STAT = sfl_pkg::OPC_STAT_DEF,
  parameter logic [7:0] OPC_LOCK = sfl_pkg::OPC_LOCK_DEF,
  parameter logic [7:0] OPC_PAGE = sfl_pkg::OPC_PAGE_DEF,
  parameter logic [7:0] OPC_B4 = sfl_pkg::OPC_B4_DEF,
  parameter logic [7:0] OPC_B64 = sfl_pkg::OPC_B64_DEF
) (
  input wire logic pclk,
  input wire logic presetn,
  sfl_if.dev link,
  input wire logic [sfl_pkg::BP_W-1:0] block_protect,
  output logic erase_start,
  output logic erase_abort,
  output sfl_pkg::sfl_kind_e erase_kind,
  output logic [sfl_pkg::ADDR_W-1:0] erase_base,
  output logic busy_flag,
  output logic write_arm_latch
);
  import sfl_pkg::*;

  // Cycle lengths are derived from the timing parameters.
  localparam logic [31:0] PAGE_CYC = 32'(PAGE_CLEAR_TIME_US * CLK_MHZ);
  localparam logic [31:0] B4_CYC = 32'(BLOCK4K_WIPE_TIME_US * CLK_MHZ);
  localparam logic [31:0] B64_CYC = 32'(BLOCK64K_WIPE_TIME_US * CLK_MHZ);
  localparam logic [31:0] REC_CYC = 32'(RECOV_CYC);

  typedef enum logic [1:0] {ST_IDLE, ST_ERASE, ST_RESET, ST_RECOVER}
    sfl_dst_e;

  sfl_dst_e state;
  sfl_dst_e next_state;
  logic [31:0] cnt;
  logic [31:0] next_cnt;
  logic [3:0] pins_s;
  logic sck_d;
  logic cs_d;
  logic live;
  logic [5:0] bitcnt;
  logic [31:0] shreg;
  logic [7:0] opcode;
  logic [23:0] addr;
  logic miso_q;
  logic [7:0] stat_byte;
  logic [1:0] sector_lock_byte [SECT_N];

  // Chip select and reset pin idle high, so their sync stages reset high.
  sfl_sync #(.W(4), .INIT(4'hA)) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .d({link.rst_pin_n, link.mosi, link.cs_n, link.sck}),
    .q(pins_s)
  );

  // Edge detection runs on the synchronised copies only.
  wire logic sck_s = pins_s[0];
  wire logic cs_s = pins_s[1];
  wire logic mosi_s = pins_s[2];
  wire logic rst_s = pins_s[3];
  wire logic sck_rise = sck_s & ~sck_d;
  wire logic sck_fall = ~sck_s & sck_d;
  wire logic cs_fall = ~cs_s & cs_d;
  wire logic cs_rise = cs_s & ~cs_d;
  wire logic [5:0] bit_next = (bitcnt == 6'h3F) ? bitcnt : bitcnt + 6'h01;
  wire logic [31:0] shreg_next = {shreg[30:0], mosi_s};

  // Command decode, judged at the chip select rise that ends a frame.
  wire logic frame_end = cs_rise & live;
  wire logic is_arm = (opcode == OPC_ARM) && (bitcnt == FRAME_ARM);
  wire logic is_lock = (opcode == OPC_LOCK) && (bitcnt == FRAME_LOCK);
  wire logic is_page = (opcode == OPC_PAGE) && (bitcnt == FRAME_ERASE);
  wire logic is_b4 = (opcode == OPC_B4) && (bitcnt == FRAME_ERASE);
  wire logic is_b64 = (opcode == OPC_B64) && (bitcnt == FRAME_ERASE);
  wire logic is_read = (opcode == OPC_STAT) && (bitcnt >= FRAME_ARM);
  wire logic idle = (state == ST_IDLE);
  wire logic [4:0] sect = addr[ADDR_W-1:SECT_LSB];
  wire logic [1:0] sect_lock = sector_lock_byte[sect];
  // Protection is per 64K sector, so page, 4K and 64K share one check.
  wire logic sect_prot = sect_lock[LOCK_WL_BIT]
                         | bp_covers(sect, block_protect);
  // Busy rejects every lock or erase and leaves the cycle alone.
  wire logic do_lock = frame_end & is_lock & write_arm_latch & idle
                       & ~sect_lock[LOCK_LD_BIT];
  wire logic do_erase = frame_end & (is_page | is_b4 | is_b64)
                        & write_arm_latch & idle & ~sect_prot;
  wire logic do_arm = frame_end & is_arm;
  wire logic [31:0] wipe_cyc = is_page ? PAGE_CYC
                               : (is_b4 ? B4_CYC : B64_CYC);
  wire sfl_kind_e wipe_kind = is_page ? K_PAGE : (is_b4 ? K_B4 : K_B64);
  // Any address inside the region selects it; low bits are dropped.
  wire logic [ADDR_W-1:0] wipe_base = is_page ?
    {addr[ADDR_W-1:PAGE_LSB], {PAGE_LSB{1'b0}}} : (is_b4 ?
    {addr[ADDR_W-1:SUB_LSB], {SUB_LSB{1'b0}}} :
    {addr[ADDR_W-1:SECT_LSB], {SECT_LSB{1'b0}}});

  assign link.miso = miso_q;

  // Status byte stays readable in every state so the host can poll.
  always_comb begin
    stat_byte = 8'h00;
    stat_byte[ST_BUSY_BIT] = busy_flag;
    stat_byte[ST_WEL_BIT] = write_arm_latch;
  end

  // Cycle sequencer; a low reset pin wins over everything else.
  always_comb begin
    next_state = state;
    next_cnt = cnt;
    case (state)
      ST_IDLE: begin
        if (!rst_s) begin
          next_state = ST_RESET;
        end else if (do_erase) begin
          next_state = ST_ERASE;
          next_cnt = wipe_cyc;
        end
      end
      ST_ERASE: begin
        if (!rst_s) begin
          next_state = ST_RESET;
        end else if (cnt <= 32'h0000_0001) begin
          next_state = ST_IDLE;
        end else begin
          next_cnt = cnt - 32'h0000_0001;
        end
      end
      ST_RESET: begin
        if (rst_s) begin
          next_state = ST_RECOVER;
          next_cnt = REC_CYC;
        end
      end
      ST_RECOVER: begin
        if (!rst_s) begin
          next_state = ST_RESET;
        end else if (cnt <= 32'h0000_0001) begin
          next_state = ST_IDLE;
        end else begin
          next_cnt = cnt - 32'h0000_0001;
        end
      end
      default: next_state = ST_IDLE;
    endcase
  end

  // Sequencer registers and the cycle outputs toward the array.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= ST_IDLE;
      cnt <= 32'h0000_0000;
      busy_flag <= 1'b0;
      erase_start <= 1'b0;
      erase_abort <= 1'b0;
      erase_kind <= K_PAGE;
      erase_base <= '0;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      busy_flag <= (next_state == ST_ERASE);
      erase_start <= do_erase;
      erase_abort <= (state == ST_ERASE) & ~rst_s;
      if (do_erase) begin
        erase_kind <= wipe_kind;
        erase_base <= wipe_base;
      end
    end
  end

  // Frame capture: bits are taken on serial clock rises while selected.
  // A frame opened in reset or recovery is never executed.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sck_d <= 1'b0;
      cs_d <= 1'b1;
      live <= 1'b0;
      bitcnt <= 6'h00;
      shreg <= 32'h0000_0000;
      opcode <= 8'h00;
      addr <= 24'h00_0000;
    end else begin
      sck_d <= sck_s;
      cs_d <= cs_s;
      if (cs_fall) begin
        bitcnt <= 6'h00;
        live <= rst_s & (idle | (state == ST_ERASE));
      end else if (sck_rise && !cs_s) begin
        bitcnt <= bit_next;
        shreg <= shreg_next;
        if (bitcnt == FRAME_ARM - 6'h01) begin
          opcode <= shreg_next[7:0];
        end
        if (bitcnt == FRAME_ERASE - 6'h01) begin
          addr <= shreg_next[23:0];
        end
      end
    end
  end

  // Status bits leave MSB first on each falling clock after the opcode.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      miso_q <= 1'b0;
    end else if (cs_s) begin
      miso_q <= 1'b0;
    end else if (sck_fall && is_read) begin
      miso_q <= stat_byte[~bitcnt[2:0]];
    end
  end

  // Write-arm latch: set by the arm frame, dropped on use or reset.
  // Clearing one cycle after the synchronised select rise lands two to three
  // pclk cycles after the pin rise, which can pass the 50 ns minimum deselect time.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      write_arm_latch <= 1'b0;
    end else if (!rst_s || do_lock || do_erase) begin
      write_arm_latch <= 1'b0;
    end else if (do_arm && idle) begin
      write_arm_latch <= 1'b1;
    end
  end

  // Volatile lock bits; only b1 and b0 of the data byte are stored.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < SECT_N; i++) begin
        sector_lock_byte[i] <= 2'h0;
      end
    end else if (!rst_s) begin
      for (int i = 0; i < SECT_N; i++) begin
        sector_lock_byte[i] <= 2'h0;
      end
    end else if (do_lock) begin
      sector_lock_byte[sect] <= shreg[1:0];
    end
  end
endmodule // sfl_dev

// ==== hw/sfl_host.sv ====
// SPI host controller: APB command registers driving the flash link.
`timescale 1ns/1ps
module sfl_host #(
  parameter logic [7:0] OPC_ARM = sfl_pkg::OPC_ARM_DEF,
  parameter logic [7:0] OPC_STAT = sfl_pkg::OPC_STAT_DEF,
  parameter logic [7:0] OPC_LOCK = sfl_pkg::OPC_LOCK_DEF,
  parameter logic [7:0] OPC_PAGE = sfl_pkg::OPC_PAGE_DEF,
  parameter logic [7:0] OPC_B4 = sfl_pkg::OPC_B4_DEF,
  parameter logic [7:0] OPC_B64 = sfl_pkg::OPC_B64_DEF
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [sfl_pkg::APB_AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  sfl_if.host link
);
  import sfl_pkg::*;

  typedef enum logic [2:0] {H_IDLE, H_SETUP, H_SHIFT, H_HOLD, H_GAP,
                            H_RST_LOW, H_RST_WAIT} sfl_hst_e;

  sfl_hst_e hstate;
  logic [15:0] tcnt;
  logic [2:0] cur_cmd;
  logic arm_first;
  logic [39:0] txsr;
  logic [7:0] rxsr;
  logic [5:0] nbits;
  logic [23:0] cmd_addr;
  logic [7:0] cmd_data;
  logic [7:0] last_status;
  logic sck_q;
  logic cs_q;
  logic mosi_q;
  logic rstp_q;
  logic miso_s;

  // Frame contents, MSB first: opcode, address, data.
  function automatic logic [39:0] frame_vec(input logic [2:0] c,
                                            input logic [23:0] a,
                                            input logic [7:0] d);
    logic [7:0] op;
    case (c)
      HC_STATUS: op = OPC_STAT;
      HC_LOCK: op = OPC_LOCK;
      HC_PAGE: op = OPC_PAGE;
      HC_B4: op = OPC_B4;
      HC_B64: op = OPC_B64;
      default: op = OPC_ARM;
    endcase
    return {op, a, d};
  endfunction

  function automatic logic [5:0] frame_len(input logic [2:0] c);
    case (c)
      HC_STATUS: return FRAME_STAT;
      HC_LOCK: return FRAME_LOCK;
      HC_PAGE, HC_B4, HC_B64: return FRAME_ERASE;
      default: return FRAME_ARM;
    endcase
  endfunction

  sfl_sync #(.W(1), .INIT(1'b0)) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .d(link.miso),
    .q(miso_s)
  );

  assign link.sck = sck_q;
  assign link.cs_n = cs_q;
  assign link.mosi = mosi_q;
  assign link.rst_pin_n = rstp_q;

  // APB decode: one wait state, writes act at the completing edge.
  wire logic acc = psel & penable & ~pready;
  wire logic wr_fire = psel & penable & pready & pwrite;
  wire logic mapped = (paddr == REG_CTRL) | (paddr == REG_ADDR)
                      | (paddr == REG_DATA) | (paddr == REG_STAT)
                      | (paddr == REG_RESET);
  wire logic hbusy = (hstate != H_IDLE);
  wire logic go = wr_fire && (paddr == REG_CTRL) && !hbusy
                  && (pwdata[2:0] <= HC_B64);
  wire logic rst_go = wr_fire && (paddr == REG_RESET) && !hbusy
                      && pwdata[0];
  // Lock and erase commands are preceded by an automatic arm frame.
  wire logic needs_arm = (pwdata[2:0] >= HC_LOCK);
  // Frame images are built here so the sequencer can pick their first bit.
  wire logic [2:0] first_cmd = needs_arm ? HC_ARM : pwdata[2:0];
  wire logic [39:0] first_vec = frame_vec(first_cmd, cmd_addr, cmd_data);
  wire logic [39:0] queued_vec = frame_vec(cur_cmd, cmd_addr, cmd_data);
  wire logic tick = (tcnt == 16'h0000);
  wire logic [15:0] half = 16'(SCK_HALF - 1);
  wire logic [31:0] rd_mux = (paddr == REG_ADDR) ? {8'h00, cmd_addr}
    : (paddr == REG_DATA) ? {24'h00_0000, cmd_data}
    : (paddr == REG_STAT) ? {16'h0000, last_status, 7'h00, hbusy}
    : 32'h0000_0000;

  // APB answer and software-visible registers.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
      cmd_addr <= 24'h00_0000;
      cmd_data <= 8'h00;
    end else begin
      pready <= acc;
      pslverr <= acc & ~mapped;
      prdata <= (acc && !pwrite) ? rd_mux : 32'h0000_0000;
      if (wr_fire && paddr == REG_ADDR) begin
        cmd_addr <= pwdata[23:0];
      end
      if (wr_fire && paddr == REG_DATA) begin
        cmd_data <= pwdata[7:0] & LOCK_DATA_MASK;
      end
    end
  end

  // Link sequencer; select stays low from opcode to last bit.
  // The serial clock is pclk divided by twice SCK_HALF.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hstate <= H_IDLE;
      tcnt <= 16'h0000;
      cur_cmd <= HC_ARM;
      arm_first <= 1'b0;
      txsr <= 40'h00_0000_0000;
      rxsr <= 8'h00;
      nbits <= 6'h00;
      last_status <= 8'h00;
      sck_q <= 1'b0;
      cs_q <= 1'b1;
      mosi_q <= 1'b0;
      rstp_q <= 1'b1;
    end else begin
      tcnt <= tick ? 16'h0000 : tcnt - 16'h0001;
      case (hstate)
        H_IDLE: begin
          if (go) begin
            cur_cmd <= pwdata[2:0];
            arm_first <= needs_arm;
            txsr <= first_vec;
            nbits <= frame_len(first_cmd);
            mosi_q <= first_vec[39];
            cs_q <= 1'b0;
            tcnt <= half;
            hstate <= H_SETUP;
          end else if (rst_go) begin
            rstp_q <= 1'b0;
            tcnt <= 16'(RST_PULSE_CYC - 1);
            hstate <= H_RST_LOW;
          end
        end
        H_SETUP: begin
          if (tick) begin
            tcnt <= half;
            hstate <= H_SHIFT;
          end
        end
        H_SHIFT: begin
          if (tick) begin
            tcnt <= half;
            sck_q <= ~sck_q;
            if (!sck_q) begin
              rxsr <= {rxsr[6:0], miso_s};
            end else begin
              txsr <= {txsr[38:0], 1'b0};
              mosi_q <= txsr[38];
              nbits <= nbits - 6'h01;
              if (nbits == 6'h01) begin
                hstate <= H_HOLD;
              end
            end
          end
        end
        H_HOLD: begin
          if (tick) begin
            cs_q <= 1'b1;
            tcnt <= 16'(GAP_CYC + SYNC_MARGIN);
            hstate <= H_GAP;
          end
        end
        H_GAP: begin
          if (tick && arm_first) begin
            arm_first <= 1'b0;
            txsr <= queued_vec;
            nbits <= frame_len(cur_cmd);
            mosi_q <= queued_vec[39];
            cs_q <= 1'b0;
            tcnt <= half;
            hstate <= H_SETUP;
          end else if (tick) begin
            if (cur_cmd == HC_STATUS) begin
              last_status <= rxsr;
            end
            hstate <= H_IDLE;
          end
        end
        H_RST_LOW: begin
          if (tick) begin
            rstp_q <= 1'b1;
            tcnt <= 16'(RECOV_CYC + SYNC_MARGIN);
            hstate <= H_RST_WAIT;
          end
        end
        H_RST_WAIT: begin
          if (tick) begin
            hstate <= H_IDLE;
          end
        end
        default: hstate <= H_IDLE;
      endcase
    end
  end
endmodule // sfl_host

// ==== hw/sfl_if.sv ====
// Pin bundle between the serial flash host and the flash device.
`timescale 1ns/1ps
interface sfl_if;
  logic sck;
  logic cs_n;
  logic mosi;
  logic miso;
  logic rst_pin_n;
  modport host (output sck, output cs_n, output mosi, output rst_pin_n,
                input miso);
  modport dev (input sck, input cs_n, input mosi, input rst_pin_n,
               output miso);
endinterface // sfl_if

// ==== hw/sfl_pkg.sv ====
// Shared constants, types and helpers for the serial flash lock/erase link.
// Function
// - Lock and erase need write-arm latch set first.
// - Lock write: opcode, three address bytes, data.
// - Lock write runs only if framed exactly.
// - Lock bits volatile, updated at once, untimed.
// - Lock write clears write-arm latch before deselect; here it clears one cycle after the synchronised select rise.
// - Lock data: b7-b2 zero, b1 lockdown, b0 lock.
// - Lock write rejected while a cycle runs.
// - Page clear sets addressed page to FFh.
// - Erases need opcode, three address bytes, exact end.
// - Erase cycle starts at the ending select rise.
// - Busy flag high during cycle; status pollable.
// - Write-arm latch cleared before erase completes.
// - Protected page is never cleared.
// - 64K wipe refused if sector holds protection.
// - 4K wipe refused if subsector holds protection.
// - Erases rejected while a cycle runs.
// - Reset pin aborts cycle; host waits recovery.
// - Address bits A23 to A21 ignored.
// - Host holds select low for whole erase frame.
// - Lockdown bit freezes lock bits until reset.
// - Write-locked sector is never modified.
package sfl_pkg;
  localparam int CLK_MHZ = 50;
  localparam int SCK_HALF = 8;
  localparam int SYNC_MARGIN = 4;
  localparam int ADDR_W = 21;
  localparam int SECT_N = 32;
  localparam int SECT_LSB = 16;
  localparam int SUB_LSB = 12;
  localparam int PAGE_LSB = 8;
  localparam int BP_W = 3;
  // Opcode defaults are arbitrary values; both ends take them as parameters.
  localparam logic [7:0] OPC_ARM_DEF = 8'h01;
  localparam logic [7:0] OPC_STAT_DEF = 8'h02;
  localparam logic [7:0] OPC_LOCK_DEF = 8'h03;
  localparam logic [7:0] OPC_PAGE_DEF = 8'h04;
  localparam logic [7:0] OPC_B4_DEF = 8'h05;
  localparam logic [7:0] OPC_B64_DEF = 8'h06;
  localparam logic [5:0] FRAME_ARM = 6'h08;
  localparam logic [5:0] FRAME_STAT = 6'h10;
  localparam logic [5:0] FRAME_ERASE = 6'h20;
  localparam logic [5:0] FRAME_LOCK = 6'h28;
  localparam int LOCK_WL_BIT = 0;
  localparam int LOCK_LD_BIT = 1;
  localparam logic [7:0] LOCK_DATA_MASK = 8'h03;
  localparam int ST_BUSY_BIT = 0;
  localparam int ST_WEL_BIT = 1;
  localparam int MIN_DESELECT_TIME_NS = 50;
  localparam int GAP_CYC = (MIN_DESELECT_TIME_NS * CLK_MHZ + 999) / 1000;
  localparam int RESET_RECOVERY_TIME_US = 20;
  localparam int RECOV_CYC = RESET_RECOVERY_TIME_US * CLK_MHZ;
  localparam int RESET_PULSE_NS = 1000;
  localparam int RST_PULSE_CYC = (RESET_PULSE_NS * CLK_MHZ + 999) / 1000;
  localparam int APB_AW = 8;
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_ADDR = 8'h04;
  localparam logic [7:0] REG_DATA = 8'h08;
  localparam logic [7:0] REG_STAT = 8'h0C;
  localparam logic [7:0] REG_RESET = 8'h10;
  localparam logic [2:0] HC_ARM = 3'h0;
  localparam logic [2:0] HC_STATUS = 3'h1;
  localparam logic [2:0] HC_LOCK = 3'h2;
  localparam logic [2:0] HC_PAGE = 3'h3;
  localparam logic [2:0] HC_B4 = 3'h4;
  localparam logic [2:0] HC_B64 = 3'h5;

  typedef enum logic [1:0] {K_PAGE, K_B4, K_B64} sfl_kind_e;

  // Block-protect covers the top 2^(bp-1) sectors; six or more covers all.
  function automatic logic bp_covers(input logic [4:0] sect,
                                     input logic [BP_W-1:0] bp);
    logic [5:0] span;
    span = (bp >= 3'h6) ? 6'h20 : 6'(1 << (bp - 3'h1));
    return (bp != 3'h0) && ({1'b0, sect} >= (6'h20 - span));
  endfunction
endpackage

// ==== hw/sfl_sync.sv ====
// Two-flop synchroniser for levels entering the pclk domain.
`timescale 1ns/1ps
module sfl_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '0
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta;

  // The first stage feeds only the second; nothing else may look at it.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta <= INIT;
      q <= INIT;
    end else begin
      meta <= d;
      q <= meta;
    end
  end
endmodule // sfl_sync

// ==== test/sfl_link_sva.sv ====
// Checker for the flash link wires and the device cycle outputs.
`timescale 1ns/1ps
module sfl_link_sva (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic sck,
  input wire logic cs_n,
  input wire logic mosi,
  input wire logic rst_pin_n,
  input wire logic erase_start,
  input wire logic erase_abort,
  input wire logic busy_flag,
  input wire logic write_arm_latch
);
  // Everything here lives in the pclk domain under the block reset.
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // A cycle may only start when armed, idle and just deselected.
  AST_START_ARMED: assert property (
    erase_start |-> $past(write_arm_latch))
    else $error("Erase began without the write-arm latch.");
  AST_START_IDLE: assert property (
    erase_start |-> !$past(busy_flag))
    else $error("Erase began while a cycle was running.");
  AST_START_DESELECT: assert property (
    erase_start |-> cs_n && $past(cs_n, 2))
    else $error("Erase began while the device was selected.");
  AST_START_EFFECT: assert property (
    erase_start |-> busy_flag && !write_arm_latch)
    else $error("Erase start did not raise busy and drop the latch.");
  AST_BUSY_CAUSE: assert property (
    $rose(busy_flag) |-> erase_start ##1 busy_flag [*7])
    else $error("Busy rose without a start or dropped too soon.");
  AST_ABORT: assert property (
    erase_abort |-> !rst_pin_n && $past(busy_flag) && !busy_flag
                    && !write_arm_latch)
    else $error("Abort seen without reset pin or left state behind.");
  AST_ARM_SET: assert property (
    $rose(write_arm_latch) |-> cs_n && !busy_flag)
    else $error("Write-arm latch set while selected or busy.");
  AST_LATCH_CLEAR: assert property (
    $fell(write_arm_latch) |-> cs_n)
    else $error("Write-arm latch cleared while still selected.");
  AST_RESET_DESELECT: assert property (
    !rst_pin_n |-> cs_n)
    else $error("Device selected while its reset pin was low.");
  AST_SCK_IDLE: assert property (
    cs_n && $past(cs_n) |-> !sck)
    else $error("Serial clock moved outside a frame.");
  AST_MOSI_STABLE: assert property (
    !cs_n && sck && $past(sck) |-> $stable(mosi))
    else $error("Data line changed while the serial clock was high.");
  AST_CS_GAP: assert property (
    $rose(cs_n) |-> cs_n [*7])
    else $error("Deselect gap between frames too short.");
  // Main scenarios: erase started, erase aborted, lock write done.
  COV_START: cover property (erase_start);
  COV_ABORT: cover property (erase_abort);
  COV_LOCK: cover property ($fell(write_arm_latch) && !busy_flag);
endmodule // sfl_link_sva

// ==== test/spi_flash_lock_and_erase_cmds_test.sv ====
// Bench joining the flash host and device ends over one link.
`timescale 1ns/1ps
module spi_flash_lock_and_erase_cmds_test;
  import sfl_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [2:0] block_protect = 3'h0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, er, erase_start, erase_abort;
  logic busy_flag, write_arm_latch;
  sfl_kind_e erase_kind;
  logic [20:0] erase_base;
  int mismatches = 0;
  int n_checks = 0;
  int starts = 0;
  int aborts = 0;
  int busy_n = 0;
  int cycles = 0;
  sfl_if link ();
  sfl_host u_sfl_host (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .link(link.host));
  // Long 64K wipe so that commands can be aimed at a running cycle.
  sfl_dev #(.PAGE_CLEAR_TIME_US(1), .BLOCK4K_WIPE_TIME_US(2),
    .BLOCK64K_WIPE_TIME_US(100)) u_sfl_dev (.pclk, .presetn,
    .link(link.dev), .block_protect, .erase_start, .erase_abort,
    .erase_kind, .erase_base, .busy_flag, .write_arm_latch);
  sfl_link_sva u_sfl_link_sva (.pclk, .presetn, .sck(link.sck),
    .cs_n(link.cs_n), .mosi(link.mosi), .rst_pin_n(link.rst_pin_n),
    .erase_start, .erase_abort, .busy_flag, .write_arm_latch);
  always #10 pclk = ~pclk;
  // Event counters and the hang limit; a hang counts as a mismatch.
  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (erase_start === 1'b1) starts <= starts + 1;
    if (erase_abort === 1'b1) aborts <= aborts + 1;
    if (busy_flag === 1'b1) busy_n <= busy_n + 1;
    if (cycles == 90000) begin
      mismatches++;
      complete_run();
    end
  end
  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // One APB transfer; the request is held until pready is sampled high.
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic host_idle;
    do apb(1'b0, REG_STAT, 32'h0); while (rd[0] !== 1'b0);
  endtask
  task automatic cmd(input logic [2:0] c, input logic [23:0] a,
                     input logic [7:0] d);
    apb(1'b1, REG_ADDR, {8'h00, a});
    apb(1'b1, REG_DATA, {24'h0, d});
    apb(1'b1, REG_CTRL, {29'h0, c});
    host_idle();
    repeat (8) @(posedge pclk);
  endtask
  task automatic settle;
    while (busy_flag === 1'b1) @(posedge pclk);
  endtask
  task automatic t_regs;
    apb(1'b0, 8'h14, 32'h0);
    check("unmapped err", er, 1);
    check("unmapped data", rd, 0);
    apb(1'b1, REG_DATA, 32'hFF);
    apb(1'b0, REG_DATA, 32'h0);
    check("data mask", rd, 32'h3);
    $display("register test done");
  endtask
  task automatic t_page;
    int s0;
    s0 = starts;
    busy_n = 0;
    cmd(HC_PAGE, 24'hE1_2345, 8'h00);
    settle();
    check("page starts", starts - s0, 1);
    check("page kind", 32'(erase_kind), 32'(K_PAGE));
    check("page base", {11'h0, erase_base}, 32'h0001_2300);
    check("page busy", busy_n, 50);
    check("page arm", write_arm_latch, 0);
    $display("page clear test done");
  endtask
  task automatic t_busy;
    int s0;
    s0 = starts;
    cmd(HC_B64, 24'hA2_ABCD, 8'h00);
    check("b64 kind", 32'(erase_kind), 32'(K_B64));
    check("b64 base", {11'h0, erase_base}, 32'h0002_0000);
    cmd(HC_STATUS, 24'h0, 8'h00);
    apb(1'b0, REG_STAT, 32'h0);
    check("polled status", rd[9:8], 2'b01);
    cmd(HC_B4, 24'h03_0000, 8'h00);
    cmd(HC_LOCK, 24'h03_0000, 8'h01);
    check("busy starts", starts - s0, 1);
    settle();
    cmd(HC_B4, 24'h03_5678, 8'h00);
    settle();
    check("b4 starts", starts - s0, 2);
    check("b4 kind", 32'(erase_kind), 32'(K_B4));
    check("b4 base", {11'h0, erase_base}, 32'h0003_5000);
    $display("busy rejection test done");
  endtask
  task automatic t_lock;
    int s0;
    s0 = starts;
    cmd(HC_LOCK, 24'h04_0000, 8'h01);
    check("lock arm", write_arm_latch, 0);
    cmd(HC_B64, 24'h04_1234, 8'h00);
    cmd(HC_B4, 24'h04_8000, 8'h00);
    cmd(HC_PAGE, 24'h04_FF00, 8'h00);
    check("locked arm", write_arm_latch, 1);
    cmd(HC_LOCK, 24'h05_0000, 8'h02);
    cmd(HC_LOCK, 24'h05_0000, 8'h01);
    cmd(HC_PAGE, 24'h05_0100, 8'h00);
    settle();
    check("lock starts", starts - s0, 1);
    $display("lock test done");
  endtask
  task automatic t_protect;
    int s0;
    s0 = starts;
    block_protect <= 3'h1;
    cmd(HC_PAGE, 24'h1F_0000, 8'h00);
    cmd(HC_B4, 24'h1E_F000, 8'h00);
    settle();
    block_protect <= 3'h0;
    check("protect starts", starts - s0, 1);
    $display("protect test done");
  endtask
  task automatic t_abort;
    int s0;
    s0 = aborts;
    cmd(HC_B64, 24'h06_0000, 8'h00);
    apb(1'b1, REG_RESET, 32'h1);
    host_idle();
    check("aborts", aborts - s0, 1);
    check("abort busy", busy_flag, 0);
    s0 = starts;
    cmd(HC_PAGE, 24'h04_0000, 8'h00);
    settle();
    check("unlocked starts", starts - s0, 1);
    $display("reset pin test done");
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // Main sequence; the scenarios build on each other's lock state.
  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_page();
    t_busy();
    t_lock();
    t_protect();
    t_abort();
    complete_run();
  end
endmodule // spi_flash_lock_and_erase_cmds_test
